//--- nv_setting_store.sv
// nonvolatile setting array with write cycle timer
`timescale 1ns/1ps
`default_nettype none
`include "quad_pot_cfg.svh"
module nv_setting_store #(
	parameter int NV_WRITE_CYCLES = `NV_WRITE_CYCLES
) (
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire logic                     wr_req,
	input  wire quad_pot_pkg::nv_write_t  wr_cmd,
	output logic                          busy,
	output logic [15:0][7:0]              settings
);
	logic [7:0]               mem_r [16] = '{default: `SETTING_INIT};
	quad_pot_pkg::nv_write_t  cmd_r;
	logic [31:0]              timer_r;
	logic                     busy_r;

	// contents survive reset: only a completed write cycle changes them
	always_ff @(posedge clk) begin
		if (busy_r && timer_r == 32'h0)
			mem_r[cmd_r.addr] <= cmd_r.data; // R16
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			busy_r  <= 1'b0;
			timer_r <= 32'h0;
			cmd_r   <= '0;
		end else if (busy_r) begin
			timer_r <= timer_r - 32'h1; // R15
			if (timer_r == 32'h0)
				busy_r <= 1'b0;
		end else if (wr_req) begin
			busy_r  <= 1'b1;
			cmd_r   <= wr_cmd;
			timer_r <= 32'(NV_WRITE_CYCLES - 1);
		end
	end

	assign busy = busy_r;

	generate
		for (genvar i = 0; i < 16; i++) begin : g_rd
			assign settings[i] = mem_r[i]; // R13
		end
	endgenerate
endmodule : nv_setting_store
`default_nettype wire

//--- quad_pot_cfg.svh
// constants for the quad potentiometer wiper and setting register logic
// What this block does
// R1 - sample incoming bits on serial clock rise
// R2 - change read data after serial clock falls
// R3 - data line only pulled low, else released
// R4 - straps are low address nibble; must match
// R5 - master addresses at most sixteen distinct devices
// R6 - write protect low blocks nonvolatile writes
// R7 - four 8-bit wipers decode to 256 taps
// R8 - write-wiper loads wiper from serial byte
// R9 - transfer loads wiper from chosen setting slot
// R10 - step command moves wiper one position per clock rise
// R11 - power-up loads wiper from slot zero
// R12 - wiper value is lost at power-down
// R13 - four 8-bit settings per channel, read/write
// R14 - copy between setting and wiper both ways
// R15 - setting changes finish within 10 ms
// R16 - all eight setting bits stored, general use
// R17 - ignore bus, no ID ack while writing
// R18 - instruction: opcode, slot bits, channel bits
// R19 - ack ID, instruction and write data bytes
// R20 - global transfer loads all four wipers
// R21 - write protect never blocks wiper loads
`ifndef QUAD_POT_CFG_SVH
`define QUAD_POT_CFG_SVH

`define CLK_FREQ_HZ       100000000
`define NV_WRITE_MS       10
`define NV_WRITE_CYCLES   (`NV_WRITE_MS * (`CLK_FREQ_HZ / 1000))

`define CHANNELS          4
`define SLOTS             4
`define TAPS              256
`define SETTING_INIT      8'h80

`define OP_GLOBAL_XFR     4'h1
`define OP_STEP           4'h2
`define OP_READ_WIPER     4'h9
`define OP_WRITE_WIPER    4'hA
`define OP_READ_SETTING   4'hB
`define OP_WRITE_SETTING  4'hC
`define OP_XFR_TO_WIPER   4'hD
`define OP_XFR_TO_SETTING 4'hE

`define ID_OPCODE_MSB     7
`define ID_OPCODE_LSB     4
`define ACK_SLOT          4'h8
`define LAST_BIT          4'h7

`endif

//--- quad_pot_monitor.sv
// assertion checker for the quad potentiometer register logic
`timescale 1ns/1ps
`default_nettype none
module quad_pot_monitor #(
	parameter int NV_WRITE_CYCLES = 50
) (
	input wire logic               clk,
	input wire logic               reset,
	input wire logic               scl,
	input wire logic               sda_in,
	input wire logic               sda_out,
	input wire logic               sda_oe,
	input wire logic [3:0]         board_address_straps,
	input wire logic               write_protect_n,
	input wire logic [3:0][7:0]    wiper_position_reg,
	input wire logic [3:0][255:0]  tap_select,
	input wire logic               nv_busy
);
	logic       scl_r;
	logic [3:0] rise_r;
	logic [3:0] fall_r;
	int         busy_r;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// cycles since the last serial clock edge, saturating
	always_ff @(posedge clk) begin
		scl_r <= scl;
		busy_r <= nv_busy ? busy_r + 1 : 0;
		if (reset) begin
			rise_r <= 4'hF;
			fall_r <= 4'hF;
		end else begin
			rise_r <= (scl && !scl_r) ? 4'h0 : rise_r + {3'h0, rise_r != 4'hF};
			fall_r <= (!scl && scl_r) ? 4'h0 : fall_r + {3'h0, fall_r != 4'hF};
		end
	end
	a_data_low: assert property (sda_out == 1'b0)
		else $error("data wire driven high");
	a_oe_after_fall: assert property (!$stable(sda_oe) |-> fall_r <= 4'h5)
		else $error("data output changed away from clock fall");
	a_wiper_on_rise: assert property (!$stable(wiper_position_reg) |-> rise_r <= 4'h5)
		else $error("wiper changed away from clock rise");
	for (genvar g = 0; g < 4; g++) begin : g_tap
		a_tap_decode: assert property (!$past(reset) |-> tap_select[g] == 256'h1 << $past(wiper_position_reg[g]))
			else $error("tap select does not follow wiper");
	end
	a_busy_length: assert property ($fell(nv_busy) |-> busy_r >= NV_WRITE_CYCLES - 1 && busy_r <= NV_WRITE_CYCLES)
		else $error("nonvolatile cycle length wrong");
	a_busy_silent: assert property (nv_busy |-> !sda_oe)
		else $error("acknowledge during nonvolatile cycle");
	a_busy_wiper: assert property (nv_busy && $past(nv_busy) |-> $stable(wiper_position_reg))
		else $error("wiper moved during nonvolatile cycle");
	a_busy_unprot: assert property ($rose(nv_busy) |-> write_protect_n && scl)
		else $error("nonvolatile cycle started while protected");
	a_reset_quiet: assert property ($fell(reset) |-> !sda_oe && !nv_busy)
		else $error("outputs active after reset");
endmodule : quad_pot_monitor
bind quad_pot_wiper_registers quad_pot_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_mon (.clk(clk),
	.reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.board_address_straps(board_address_straps), .write_protect_n(write_protect_n),
	.wiper_position_reg(wiper_position_reg), .tap_select(tap_select), .nv_busy(nv_busy));
`default_nettype wire

//--- quad_pot_pkg.sv
// types shared by the quad potentiometer register logic
package quad_pot_pkg;

	typedef enum {
		S_IDLE,
		S_ID,
		S_INSTR,
		S_WDATA,
		S_STEP,
		S_RDATA,
		S_RACK,
		S_WAIT
	} bus_state_t;

	typedef struct packed {
		logic [3:0] opcode;
		logic       slot_select_hi;
		logic       slot_select_lo;
		logic       channel_select_hi;
		logic       channel_select_lo;
	} instr_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
	} nv_write_t;

	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start_det;
		logic stop_det;
		logic sda_level;
	} bus_events_t;

endpackage : quad_pot_pkg

//--- quad_pot_wiper_registers.sv
// serial slave, wiper registers and tap decode of the quad potentiometer
`timescale 1ns/1ps
`default_nettype none
`include "quad_pot_cfg.svh"
module quad_pot_wiper_registers #(
	parameter int         NV_WRITE_CYCLES = `NV_WRITE_CYCLES,
	parameter logic [3:0] DEVICE_TYPE_ID  = 4'hA // arbitrary value
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              scl,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire logic [3:0]        board_address_straps,
	input  wire logic              write_protect_n,
	output logic [3:0][7:0]        wiper_position_reg,
	output logic [3:0][255:0]      tap_select,
	output logic                   nv_busy
);
	quad_pot_pkg::bus_events_t  ev;
	quad_pot_pkg::bus_state_t   state_r;
	quad_pot_pkg::bus_state_t   next_state_r;
	quad_pot_pkg::bus_state_t   nxt_now;
	quad_pot_pkg::instr_t       instr_r;
	quad_pot_pkg::instr_t       instr_in;
	quad_pot_pkg::nv_write_t    pend_r;
	logic [3:0]                 bit_cnt_r;
	logic [7:0]                 shift_r;
	logic                       ack_ok_r;
	logic                       ack_on_r;
	logic                       acked_r;
	logic                       sda_drive_r;
	logic [7:0]                 rbyte_r;
	logic [7:0]                 wiper_r [4];
	logic [3:0][255:0]          tap_r;
	logic                       pend_valid_r;
	logic [3:0]                 strap_s1;
	logic [3:0]                 strap_s2;
	logic                       wp_s1;
	logic                       wp_s2;
	logic [15:0][7:0]           settings;
	logic                       busy;

	wire [7:0] byte_in   = {shift_r[6:0], ev.sda_level};
	wire       rx_state  = (state_r == quad_pot_pkg::S_ID) || (state_r == quad_pot_pkg::S_INSTR) ||
	                       (state_r == quad_pot_pkg::S_WDATA);
	wire       byte_done = ev.scl_rise && rx_state && bit_cnt_r == `LAST_BIT;
	wire       id_match  = byte_in == {DEVICE_TYPE_ID, strap_s2}; // R4
	wire [1:0] ch_in     = {instr_in.channel_select_hi, instr_in.channel_select_lo};
	wire [1:0] slot_in   = {instr_in.slot_select_hi, instr_in.slot_select_lo};
	wire [1:0] ch_r      = {instr_r.channel_select_hi, instr_r.channel_select_lo};
	wire [1:0] slot_r    = {instr_r.slot_select_hi, instr_r.slot_select_lo};
	wire       instr_done = byte_done && state_r == quad_pot_pkg::S_INSTR && instr_ok(instr_in);
	wire       wdata_done = byte_done && state_r == quad_pot_pkg::S_WDATA;
	wire       step_now   = ev.scl_rise && state_r == quad_pot_pkg::S_STEP;
	wire       ack_ok_now = (state_r == quad_pot_pkg::S_ID) ? id_match :
	                        (state_r == quad_pot_pkg::S_INSTR) ? instr_ok(instr_in) : 1'b1; // R19
	wire       nv_wr_req  = ev.stop_det && pend_valid_r && wp_s2; // R6 R21

	assign instr_in = quad_pot_pkg::instr_t'(byte_in); // R18

	// instruction legality; global transfer needs both channel bits clear
	function automatic logic instr_ok(input quad_pot_pkg::instr_t i);
		case (i.opcode)
			`OP_STEP, `OP_READ_WIPER, `OP_WRITE_WIPER, `OP_READ_SETTING,
			`OP_WRITE_SETTING, `OP_XFR_TO_WIPER, `OP_XFR_TO_SETTING: instr_ok = 1'b1;
			`OP_GLOBAL_XFR: instr_ok = !i.channel_select_hi && !i.channel_select_lo; // R20
			default: instr_ok = 1'b0;
		endcase
	endfunction : instr_ok

	function automatic logic [3:0] slot_index(input logic [1:0] ch, input logic [1:0] slot);
		slot_index = {ch, slot};
	endfunction : slot_index

	// one step up for a high data bit, down for low, clamped at the ends
	function automatic logic [7:0] step_value(input logic [7:0] w, input logic up);
		if (up)
			step_value = (w == 8'hFF) ? w : w + 8'h01;
		else
			step_value = (w == 8'h00) ? w : w - 8'h01;
	endfunction : step_value

	always_comb begin
		nxt_now = quad_pot_pkg::S_WAIT;
		case (state_r)
			quad_pot_pkg::S_ID: nxt_now = quad_pot_pkg::S_INSTR;
			quad_pot_pkg::S_WDATA: nxt_now = quad_pot_pkg::S_WDATA;
			quad_pot_pkg::S_INSTR: begin
				case (instr_in.opcode)
					`OP_READ_WIPER, `OP_READ_SETTING: nxt_now = quad_pot_pkg::S_RDATA;
					`OP_WRITE_WIPER, `OP_WRITE_SETTING: nxt_now = quad_pot_pkg::S_WDATA;
					`OP_STEP: nxt_now = quad_pot_pkg::S_STEP;
					default: nxt_now = quad_pot_pkg::S_WAIT;
				endcase
			end
			default: nxt_now = quad_pot_pkg::S_WAIT;
		endcase
	end

	serial_bit_port u_port (
		.clk    (clk),
		.reset  (reset),
		.scl    (scl),
		.sda_in (sda_in),
		.events (ev)
	);

	nv_setting_store #(
		.NV_WRITE_CYCLES (NV_WRITE_CYCLES)
	) u_store (
		.clk      (clk),
		.reset    (reset),
		.wr_req   (nv_wr_req),
		.wr_cmd   (pend_r),
		.busy     (busy),
		.settings (settings)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			strap_s1 <= 4'h0;
			strap_s2 <= 4'h0;
			wp_s1    <= 1'b0;
			wp_s2    <= 1'b0;
		end else begin
			strap_s1 <= board_address_straps;
			strap_s2 <= strap_s1;
			wp_s1    <= write_protect_n;
			wp_s2    <= wp_s1;
		end
	end

	// bus sequencer: byte reception, acknowledge slots and read shifting
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r      <= quad_pot_pkg::S_IDLE;
			next_state_r <= quad_pot_pkg::S_IDLE;
			bit_cnt_r    <= 4'h0;
			shift_r      <= 8'h00;
			ack_ok_r     <= 1'b0;
			ack_on_r     <= 1'b0;
			acked_r      <= 1'b0;
			sda_drive_r  <= 1'b0;
		end else if (ev.stop_det) begin
			state_r     <= quad_pot_pkg::S_IDLE;
			sda_drive_r <= 1'b0;
			ack_on_r    <= 1'b0;
		end else if (ev.start_det) begin
			state_r     <= busy ? quad_pot_pkg::S_IDLE : quad_pot_pkg::S_ID; // R17
			bit_cnt_r   <= 4'h0;
			sda_drive_r <= 1'b0;
			ack_on_r    <= 1'b0;
			acked_r     <= 1'b0;
		end else begin
			case (state_r)
				quad_pot_pkg::S_ID, quad_pot_pkg::S_INSTR, quad_pot_pkg::S_WDATA: begin
					if (ev.scl_rise && bit_cnt_r < `ACK_SLOT) begin
						shift_r   <= byte_in; // R1
						bit_cnt_r <= bit_cnt_r + 4'h1;
						if (bit_cnt_r == `LAST_BIT) begin
							ack_ok_r     <= ack_ok_now;
							next_state_r <= nxt_now;
						end
					end
					if (ev.scl_fall && bit_cnt_r == `ACK_SLOT) begin
						if (!ack_on_r) begin
							if (ack_ok_r) begin
								sda_drive_r <= 1'b1; // R19
								ack_on_r    <= 1'b1;
							end else begin
								state_r <= quad_pot_pkg::S_WAIT;
							end
						end else begin
							sda_drive_r <= (next_state_r == quad_pot_pkg::S_RDATA) && !rbyte_r[7]; // R2
							ack_on_r    <= 1'b0;
							bit_cnt_r   <= 4'h0;
							state_r     <= next_state_r;
						end
					end
				end
				quad_pot_pkg::S_RDATA: begin
					if (ev.scl_rise && bit_cnt_r < `ACK_SLOT)
						bit_cnt_r <= bit_cnt_r + 4'h1;
					if (ev.scl_fall) begin
						if (bit_cnt_r == `ACK_SLOT) begin
							sda_drive_r <= 1'b0;
							state_r     <= quad_pot_pkg::S_RACK;
						end else begin
							sda_drive_r <= !rbyte_r[3'(`LAST_BIT - bit_cnt_r)]; // R2 R3
						end
					end
				end
				quad_pot_pkg::S_RACK: begin
					if (ev.scl_rise) begin
						if (!ev.sda_level)
							acked_r <= 1'b1;
						else
							state_r <= quad_pot_pkg::S_WAIT;
					end
					if (ev.scl_fall && acked_r) begin
						acked_r     <= 1'b0;
						bit_cnt_r   <= 4'h0;
						sda_drive_r <= !rbyte_r[7];
						state_r     <= quad_pot_pkg::S_RDATA;
					end
				end
				default: begin
					sda_drive_r <= 1'b0;
				end
			endcase
		end
	end

	// instruction register, read byte and pending nonvolatile write
	always_ff @(posedge clk) begin
		if (reset) begin
			instr_r      <= '0;
			rbyte_r      <= 8'h00;
			pend_r       <= '0;
			pend_valid_r <= 1'b0;
		end else begin
			if (ev.stop_det)
				pend_valid_r <= 1'b0;
			if (instr_done) begin
				instr_r <= instr_in;
				if (instr_in.opcode == `OP_READ_WIPER)
					rbyte_r <= wiper_r[ch_in];
				else
					rbyte_r <= settings[slot_index(ch_in, slot_in)]; // R13
				if (instr_in.opcode == `OP_XFR_TO_SETTING) begin
					pend_r       <= '{addr: slot_index(ch_in, slot_in), data: wiper_r[ch_in]}; // R14
					pend_valid_r <= 1'b1;
				end
			end
			if (wdata_done && instr_r.opcode == `OP_WRITE_SETTING) begin
				pend_r       <= '{addr: slot_index(ch_r, slot_r), data: byte_in}; // R13
				pend_valid_r <= 1'b1;
			end
		end
	end

	// wiper registers: recall, transfers, serial load and stepping
	always_ff @(posedge clk) begin
		for (int c = 0; c < `CHANNELS; c++) begin
			if (reset)
				wiper_r[c] <= settings[slot_index(2'(c), 2'h0)]; // R11 R12
			else if (instr_done && instr_in.opcode == `OP_GLOBAL_XFR)
				wiper_r[c] <= settings[slot_index(2'(c), slot_in)]; // R20
			else if (instr_done && instr_in.opcode == `OP_XFR_TO_WIPER && ch_in == 2'(c))
				wiper_r[c] <= settings[slot_index(ch_in, slot_in)]; // R9 R14
			else if (wdata_done && instr_r.opcode == `OP_WRITE_WIPER && ch_r == 2'(c))
				wiper_r[c] <= byte_in; // R8 R21
			else if (step_now && ch_r == 2'(c))
				wiper_r[c] <= step_value(wiper_r[c], ev.sda_level); // R10
		end
	end

	always_ff @(posedge clk) begin
		for (int c = 0; c < `CHANNELS; c++) begin
			if (reset)
				tap_r[c] <= 256'h0;
			else
				tap_r[c] <= 256'h1 << wiper_r[c]; // R7
		end
	end

	generate
		for (genvar c = 0; c < `CHANNELS; c++) begin : g_out
			assign wiper_position_reg[c] = wiper_r[c];
		end
	endgenerate

	assign tap_select = tap_r;
	assign sda_out    = 1'b0; // R3
	assign sda_oe     = sda_drive_r; // R3
	assign nv_busy    = busy; // R15
endmodule : quad_pot_wiper_registers
`default_nettype wire

//--- serial_bit_port.sv
// synchronises the serial pins and reports edges, start and stop
`timescale 1ns/1ps
`default_nettype none
module serial_bit_port (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  scl,
	input  wire logic                  sda_in,
	output quad_pot_pkg::bus_events_t  events
);
	logic [2:0] scl_r;
	logic [2:0] sda_r;

	// stage 0 feeds only stage 1; edges look at stages 1 and 2
	always_ff @(posedge clk) begin
		if (reset) begin
			scl_r <= 3'h7;
			sda_r <= 3'h7;
		end else begin
			scl_r <= {scl_r[1:0], scl};
			sda_r <= {sda_r[1:0], sda_in};
		end
	end

	assign events.scl_rise  = scl_r[1] & ~scl_r[2]; // R1
	assign events.scl_fall  = ~scl_r[1] & scl_r[2]; // R2
	assign events.start_det = scl_r[1] & scl_r[2] & ~sda_r[1] & sda_r[2];
	assign events.stop_det  = scl_r[1] & scl_r[2] & sda_r[1] & ~sda_r[2];
	assign events.sda_level = sda_r[1];
endmodule : serial_bit_port
`default_nettype wire

//--- serial_bus_master.sv
// bus master model driving the serial clock and the data wire
`timescale 1ns/1ps
`default_nettype none
module serial_bus_master (
	input  wire logic clk,
	input  wire logic sda_line,
	output var logic  scl,
	output var logic  sda_drv
);
	// clock idles high between frames, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task half;
		repeat (4) @(negedge clk);
	endtask : half
	// data moves mid low phase, sampled at end of high phase
	task bitx(input logic v, output logic s);
		repeat (2) @(negedge clk);
		sda_drv = v;
		repeat (2) @(negedge clk);
		scl = 1'b1;
		half;
		s = sda_line;
		scl = 1'b0;
	endtask : bitx
	task start;
		sda_drv = 1'b1;
		half;
		scl = 1'b1;
		half;
		sda_drv = 1'b0;
		half;
		scl = 1'b0;
	endtask : start
	task stop;
		repeat (2) @(negedge clk);
		sda_drv = 1'b0;
		half;
		scl = 1'b1;
		half;
		sda_drv = 1'b1;
		half;
	endtask : stop
	task wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(b[i], s);
		bitx(1'b1, s);
		ack = ~s;
	endtask : wbyte
	task rbyte(input logic ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
		bitx(~ack, s);
	endtask : rbyte
endmodule : serial_bus_master
`default_nettype wire

//--- tb_quad_pot_wiper_registers.sv
// self-checking testbench for the quad potentiometer register logic
`timescale 1ns/1ps
`default_nettype none
`include "quad_pot_cfg.svh"
module tb_quad_pot_wiper_registers;
	localparam int         NV      = 200;
	localparam logic [3:0] DEV_ID  = 4'hA; // arbitrary value
	localparam logic [3:0] STRAPS  = 4'h9;
	localparam logic [7:0] ID_BYTE = {DEV_ID, STRAPS};
	typedef struct packed { logic [1:0] ch; logic [7:0] val; } row_t;
	row_t            rows [4] = '{'{2'h0, 8'h00}, '{2'h1, 8'h7F}, '{2'h2, 8'h5A}, '{2'h3, 8'hA5}};
	logic            clk, reset, scl, sda_drv, sda_out, sda_oe, wp_n, nv_busy, ack;
	logic [3:0]      straps;
	logic [3:0][7:0] wiper;
	logic [3:0][255:0] taps;
	logic [7:0]      rd;
	int              mismatches, total_checks;
	wire logic       sda_line;
	assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
	quad_pot_wiper_registers #(.NV_WRITE_CYCLES(NV), .DEVICE_TYPE_ID(DEV_ID)) u_dut (.clk(clk), .reset(reset),
		.scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .board_address_straps(straps),
		.write_protect_n(wp_n), .wiper_position_reg(wiper), .tap_select(taps), .nv_busy(nv_busy));
	serial_bus_master u_master (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	// mode 0 instruction only, 1 write a byte, 2 read a byte; exp holds id and instruction acks
	task cmd(input logic [7:0] id, input logic [7:0] ins, input logic [7:0] dat, input int mode,
		input logic [1:0] exp);
		u_master.start;
		u_master.wbyte(id, ack);
		check(ack, exp[1], "id ack");
		if (exp[1]) begin
			u_master.wbyte(ins, ack);
			check(ack, exp[0], "instr ack");
			if (mode == 1) begin
				u_master.wbyte(dat, ack);
				check(ack, 1'b1, "data ack");
			end
			if (mode == 2) u_master.rbyte(1'b0, rd);
		end
		u_master.stop;
	endtask : cmd
	task nv_wait;
		int n;
		repeat (8) @(negedge clk);
		check(nv_busy, 1'b1, "busy");
		cmd(ID_BYTE, 8'h00, 8'h00, 0, 2'h0);
		for (n = 0; n < NV + 20 && nv_busy; n++) @(negedge clk);
		check(n <= NV, 1'b1, "nv time");
		if (nv_busy) conclude;
	endtask : nv_wait
	// wiper is checked before the stop, whose own clock rise would step again
	task step(input logic [1:0] ch, input logic [3:0] dirs, input logic [7:0] exp);
		logic s;
		u_master.start;
		u_master.wbyte(ID_BYTE, ack);
		u_master.wbyte({`OP_STEP, 2'h0, ch}, ack);
		check(ack, 1'b1, "step ack");
		for (int i = 3; i >= 0; i--) u_master.bitx(dirs[i], s);
		repeat (8) @(negedge clk);
		check(wiper[ch], exp, "step");
		u_master.stop;
	endtask : step
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		check(1'b0, 1'b1, "timeout");
		conclude;
	end
	initial begin
		reset = 1'b1;
		wp_n = 1'b1;
		straps = STRAPS;
		mismatches = 0;
		total_checks = 0;
		repeat (6) @(negedge clk);
		reset = 1'b0;
		repeat (6) @(negedge clk);
		for (int i = 0; i < 4; i++) check(wiper[i], `SETTING_INIT, "recall");
		foreach (rows[i]) begin
			cmd(ID_BYTE, {`OP_WRITE_WIPER, 2'h0, rows[i].ch}, rows[i].val, 1, 2'h3);
			check(wiper[rows[i].ch], rows[i].val, "wiper");
			check(taps[rows[i].ch] == (256'h1 << rows[i].val), 1'b1, "tap");
			cmd(ID_BYTE, {`OP_READ_WIPER, 2'h0, rows[i].ch}, 8'h00, 2, 2'h3);
			check(rd, rows[i].val, "read wiper");
		end
		cmd({DEV_ID, STRAPS ^ 4'h1}, 8'h00, 8'h00, 0, 2'h0);
		cmd(ID_BYTE, {`OP_WRITE_SETTING, 2'h2, 2'h1}, 8'h3C, 1, 2'h3);
		nv_wait;
		cmd(ID_BYTE, {`OP_READ_SETTING, 2'h2, 2'h1}, 8'h00, 2, 2'h3);
		check(rd, 8'h3C, "setting");
		cmd(ID_BYTE, {`OP_XFR_TO_WIPER, 2'h2, 2'h1}, 8'h00, 0, 2'h3);
		check(wiper[1], 8'h3C, "xfr");
		wp_n = 1'b0;
		cmd(ID_BYTE, {`OP_WRITE_SETTING, 2'h2, 2'h1}, 8'hC3, 1, 2'h3);
		repeat (8) @(negedge clk);
		check(nv_busy, 1'b0, "protected");
		cmd(ID_BYTE, {`OP_WRITE_WIPER, 2'h0, 2'h2}, 8'hFF, 1, 2'h3);
		check(wiper[2], 8'hFF, "wp wiper");
		wp_n = 1'b1;
		cmd(ID_BYTE, {`OP_READ_SETTING, 2'h2, 2'h1}, 8'h00, 2, 2'h3);
		check(rd, 8'h3C, "kept");
		cmd(ID_BYTE, {`OP_XFR_TO_SETTING, 2'h3, 2'h3}, 8'h00, 0, 2'h3);
		nv_wait;
		cmd(ID_BYTE, {`OP_READ_SETTING, 2'h3, 2'h3}, 8'h00, 2, 2'h3);
		check(rd, 8'hA5, "to setting");
		step(2'h2, 4'hF, 8'hFF);
		cmd(ID_BYTE, {`OP_GLOBAL_XFR, 2'h3, 2'h1}, 8'h00, 0, 2'h2);
		cmd(ID_BYTE, {`OP_GLOBAL_XFR, 2'h2, 2'h0}, 8'h00, 0, 2'h3);
		for (int i = 0; i < 4; i++) check(wiper[i], (i == 1) ? 8'h3C : 8'h80, "global");
		step(2'h0, 4'hE, 8'h82);
		reset = 1'b1;
		repeat (6) @(negedge clk);
		reset = 1'b0;
		repeat (6) @(negedge clk);
		for (int i = 0; i < 4; i++) check(wiper[i], 8'h80, "power cycle");
		conclude;
	end
endmodule : tb_quad_pot_wiper_registers
`default_nettype wire
